// *** testbench.sv ***
/*
 Self-checking bench for the wait one-shot pulse timer: register table, one-shot timing,
 interrupt gating, forced halt and pin trigger.
 Assumes the package, the defines header and the timer module are compiled first.
*/
`include "wait_oneshot_defines.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLOCK, RST, WR, RD, EXT_TRIG, PULSE_OUT, IRQ;
	logic [2:0] ADDR;
	logic [7:0] WDATA, RDATA, v;
	int errors, samples_checked, n;
	logic [7:0] reset_vals [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00};
	// Address, write data, read-back value
	logic [18:0] rows [8] = '{
		{`OFS_MODE, 8'hff, 8'hff}, {`OFS_IO_CTRL, 8'hff, 8'h07},
		{`OFS_PRESCALER, 8'h5a, 8'h5a}, {`OFS_WAIT_LEN, 8'ha5, 8'ha5},
		{`OFS_PULSE_LEN, 8'h3c, 8'h3c}, {`OFS_IRQ_CTRL, 8'hc0, 8'h80},
		{`OFS_CONTROL, 8'h04, 8'h00}, {`OFS_ONESHOT, 8'h01, 8'h00}};

	wait_oneshot_pulse_timer DUT(.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .EXT_TRIG(EXT_TRIG), .PULSE_OUT(PULSE_OUT),
		.IRQ(IRQ));

	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end

	task automatic close_out;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		chk({8'h00, RDATA}, {8'h00, exp});
	endtask

	task automatic edges_until(input logic lvl, output int cnt);
		cnt = 0;
		do begin
			@(posedge CLOCK);
			#1;
			cnt++;
		end while (PULSE_OUT !== lvl && cnt < 2000);
		if (cnt >= 2000) begin
			errors++;
			close_out();
		end
	endtask

	// Held over several clocks so the synchroniser sees it
	task automatic trig;
		@(posedge CLOCK);
		EXT_TRIG <= 1'b1;
		repeat (4) @(posedge CLOCK);
		EXT_TRIG <= 1'b0;
		repeat (8) @(posedge CLOCK);
	endtask

	initial begin
		RST = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 3'h0;
		WDATA = 8'h00;
		EXT_TRIG = 1'b0;
		errors = 0;
		samples_checked = 0;
		repeat (6) @(posedge CLOCK);
		RST <= 1'b0;
		for (int i = 0; i < 8; i++) rchk(i[2:0], reset_vals[i]);
		chk_pin(PULSE_OUT, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][18:16], rows[i][15:8]);
			rchk(rows[i][18:16], rows[i][7:0]);
		end
		wr(`OFS_MODE, 8'h03);
		wr(`OFS_IO_CTRL, 8'h00);
		wr(`OFS_PRESCALER, 8'h01);
		wr(`OFS_WAIT_LEN, 8'h02);
		wr(`OFS_PULSE_LEN, 8'h03);
		wr(`OFS_IRQ_CTRL, 8'h80);
		wr(`OFS_CONTROL, 8'h01);
		repeat (2) @(posedge CLOCK);
		rchk(`OFS_CONTROL, 8'h03);
		rchk(`OFS_ONESHOT, 8'h00);
		wr(`OFS_ONESHOT, 8'h01);
		edges_until(1'b1, n);
		chk(n[15:0], 16'd6);
		edges_until(1'b0, n);
		chk(n[15:0], 16'd8);
		chk_pin(IRQ, 1'b1);
		wr(`OFS_IRQ_CTRL, 8'h40);
		#1 chk_pin(IRQ, 1'b0);
		rchk(`OFS_IRQ_CTRL, 8'h40);
		wr(`OFS_IRQ_CTRL, 8'hc0);
		#1 chk_pin(IRQ, 1'b1);
		wr(`OFS_IRQ_CTRL, 8'h80);
		#1 chk_pin(IRQ, 1'b0);
		rchk(`OFS_IRQ_CTRL, 8'h80);
		// Long wait, then halt while the pulse is high
		wr(`OFS_PRESCALER, 8'hff);
		wr(`OFS_WAIT_LEN, 8'h00);
		wr(`OFS_PULSE_LEN, 8'hff);
		repeat (2) @(posedge CLOCK);
		wr(`OFS_ONESHOT, 8'h01);
		edges_until(1'b1, n);
		chk(n[15:0], 16'd256);
		rchk(`OFS_ONESHOT, 8'h04);
		wr(`OFS_CONTROL, 8'h04);
		#1 chk_pin(PULSE_OUT, 1'b0);
		rchk(`OFS_CONTROL, 8'h00);
		rchk(`OFS_ONESHOT, 8'h00);
		// Pin trigger ignored while disabled, then accepted
		wr(`OFS_CONTROL, 8'h01);
		repeat (2) @(posedge CLOCK);
		trig();
		rchk(`OFS_ONESHOT, 8'h00);
		wr(`OFS_CONTROL, 8'h00);
		repeat (2) @(posedge CLOCK);
		rchk(`OFS_CONTROL, 8'h00);
		wr(`OFS_IO_CTRL, 8'h04);
		wr(`OFS_CONTROL, 8'h01);
		repeat (2) @(posedge CLOCK);
		trig();
		rchk(`OFS_ONESHOT, 8'h04);
		// Cascaded 16-bit count on the half-rate source, reload-only writes
		wr(`OFS_CONTROL, 8'h04);
		wr(`OFS_MODE, 8'h3f);
		wr(`OFS_IO_CTRL, 8'h00);
		wr(`OFS_PRESCALER, 8'h01);
		wr(`OFS_WAIT_LEN, 8'h01);
		wr(`OFS_PULSE_LEN, 8'h00);
		wr(`OFS_CONTROL, 8'h01);
		repeat (2) @(posedge CLOCK);
		wr(`OFS_ONESHOT, 8'h01);
		wr(`OFS_WAIT_LEN, 8'h00);
		edges_until(1'b1, n);
		// Free divider phase leaves one clock of slack
		chk((n[15:0] + 16'd3) >> 1, 16'd258);
		edges_until(1'b0, n);
		chk(n[15:0], 16'd4);
		chk_pin(IRQ, 1'b1);
		rchk(`OFS_WAIT_LEN, 8'h00);
		// Source cut off: a launched one-shot must not count
		wr(`OFS_MODE, 8'hb3);
		wr(`OFS_PRESCALER, 8'h05);
		wr(`OFS_WAIT_LEN, 8'h05);
		repeat (2) @(posedge CLOCK);
		wr(`OFS_ONESHOT, 8'h01);
		repeat (20) @(posedge CLOCK);
		rchk(`OFS_PRESCALER, 8'h05);
		rchk(`OFS_ONESHOT, 8'h04);
		wr(`OFS_CONTROL, 8'h04);
		rchk(`OFS_ONESHOT, 8'h00);
		close_out();
	end
endmodule

// *** wait_oneshot_defines.svh ***
/*
 Offsets, field positions, reset values and count-source codes of the wait one-shot timer.
 Assumes inclusion by bare name from the testbench and the timer module.
*/
// Overview of operation
// - Run bit set keeps counting; clear stops
// - Read-only flag shows counting really active
// - Halt bit stops at once; reads zero
// - Halt reinitialises counters, length registers, flags except request, pin
// - Enable bit gates the interrupt output
// - Request flag readable; writing zero clears
// - Mode field 11 selects wait one-shot
// - Select bit: 8+8 cascade or 16-bit
// - Reload-only write leaves running counter alone
// - Source field picks clock; 011 is half
// - Cutoff bit one removes the count source
// - Polarity zero: high pulse, low otherwise
// - Switch bit zero routes waveform to pin
// - Trigger enable zero ignores the pin
// - Prescaler counts source, any 8-bit value
// - Primary counts underflows, sets wait length
// - Secondary counts underflows, sets pulse length
// - 16-bit: prescaler low byte, primary/secondary high
// - Launch bit starts one-shot; reads zero
// - Read-only flag set during whole one-shot
// - Completion underflow raises the interrupt request
`ifndef WAIT_ONESHOT_DEFINES_SVH
`define WAIT_ONESHOT_DEFINES_SVH

`define OFS_CONTROL 3'h0
`define OFS_IRQ_CTRL 3'h1
`define OFS_MODE 3'h2
`define OFS_IO_CTRL 3'h3
`define OFS_PRESCALER 3'h4
`define OFS_WAIT_LEN 3'h5
`define OFS_PULSE_LEN 3'h6
`define OFS_ONESHOT 3'h7

`define BIT_RUN 0
`define BIT_ACTIVE 1
`define BIT_HALT 2
`define BIT_IRQ_FLAG 6
`define BIT_IRQ_EN 7
`define BIT_WIDE 2
`define BIT_RELOAD_ONLY 3
`define BIT_CUTOFF 7
`define BIT_POLARITY 0
`define BIT_SWITCH 1
`define BIT_PIN_TRIG 2
`define BIT_LAUNCH 0
`define BIT_OS_ACTIVE 2

`define MODE_ONESHOT 2'h3
`define SRC_DIV1 3'h0
`define SRC_DIV8 3'h1
`define SRC_DIV4 3'h2
`define SRC_DIV2 3'h3

`define RST_COUNT 8'hff
`define RST_MODE 8'h00
`define RST_IO 3'h0
`define WRAP_LOW 8'hff

`endif

// *** wait_oneshot_pkg.sv ***
/*
 Types shared by the wait one-shot timer: phase encoding and the state record.
 Assumes wait_oneshot_defines.svh is on the include path.
*/
package wait_oneshot_pkg;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_WAIT = 3'b010,
		PH_PULSE = 3'b100
	} phase_t;

	typedef struct packed {
		logic run;
		logic active;
		phase_t phase;
		logic irq_en;
		logic irq_flag;
		logic [7:0] mode;
		logic [2:0] io;
		logic [7:0] prescaler;
		logic [7:0] wait_len;
		logic [7:0] pulse_len;
		logic [7:0] pre_cnt;
		logic [7:0] main_cnt;
		logic [3:0] div;
		logic [1:0] sync;
		logic trig_prev;
		logic pin;
		logic [7:0] rdata;
	} state_t;
endpackage

// *** wait_oneshot_pulse_timer.sv ***
/*
 Wait one-shot pulse timer: 8-bit prescaler plus 8-bit counter, or one 16-bit counter,
 with register port, pulse output pin and interrupt request.
 Assumes a single 200 MHz clock, synchronous reset and an asynchronous trigger pin.
*/
`include "wait_oneshot_defines.svh"

module wait_oneshot_pulse_timer
	import wait_oneshot_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic EXT_TRIG,
	output logic PULSE_OUT,
	output logic IRQ
);
	state_t s;
	state_t next_s;

	// One-cycle enable from the free-running divider
	function automatic logic src_tick(input logic [2:0] sel, input logic [3:0] div);
		case (sel)
			`SRC_DIV1: src_tick = 1'b1;
			`SRC_DIV2: src_tick = div[0];
			`SRC_DIV4: src_tick = &div[1:0];
			`SRC_DIV8: src_tick = &div[2:0];
			default: src_tick = &div;
		endcase
	endfunction

	// Idle level equals the polarity bit; with the switch bit clear, pulse is its inverse
	function automatic logic pin_level(input phase_t ph, input logic [2:0] io);
		if (io[`BIT_SWITCH]) begin
			pin_level = io[`BIT_POLARITY];
		end else begin
			pin_level = (ph == PH_PULSE) ^ io[`BIT_POLARITY];
		end
	endfunction

	function automatic logic [7:0] read_reg(input logic [2:0] a, input state_t st);
		logic busy;
		busy = (st.phase != PH_IDLE);
		case (a)
			`OFS_CONTROL: read_reg = {5'h00, 1'b0, st.active, st.run};
			`OFS_IRQ_CTRL: read_reg = {st.irq_en, st.irq_flag, 6'h00};
			`OFS_MODE: read_reg = st.mode;
			`OFS_IO_CTRL: read_reg = {5'h00, st.io};
			`OFS_PRESCALER: read_reg = busy ? st.pre_cnt : st.prescaler;
			`OFS_WAIT_LEN: read_reg = (st.phase == PH_WAIT) ? st.main_cnt : st.wait_len;
			`OFS_PULSE_LEN: read_reg = (st.phase == PH_PULSE) ? st.main_cnt : st.pulse_len;
			`OFS_ONESHOT: read_reg = {5'h00, busy, 2'h0};
			default: read_reg = 8'h00;
		endcase
	endfunction

	logic halt;
	logic launch;
	logic tick;

	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.sync = {s.sync[0], EXT_TRIG};
		next_s.trig_prev = s.sync[1];
		next_s.div = s.div + 4'h1;
		next_s.active = s.run;
		halt = WR && (ADDR == `OFS_CONTROL) && WDATA[`BIT_HALT];
		// Pin edge only counts when enabled; otherwise software alone starts
		launch = s.run && (s.mode[1:0] == `MODE_ONESHOT) && (s.phase == PH_IDLE)
			&& ((WR && (ADDR == `OFS_ONESHOT) && WDATA[`BIT_LAUNCH])
			|| (s.io[`BIT_PIN_TRIG] && s.sync[1] && !s.trig_prev));
		tick = s.run && !s.mode[`BIT_CUTOFF] && (s.phase != PH_IDLE)
			&& src_tick(s.mode[6:4], s.div);

		if (WR) begin
			case (ADDR)
				`OFS_CONTROL: next_s.run = WDATA[`BIT_RUN];
				`OFS_IRQ_CTRL: begin
					next_s.irq_en = WDATA[`BIT_IRQ_EN];
					if (!WDATA[`BIT_IRQ_FLAG]) begin
						next_s.irq_flag = 1'b0;
					end
				end
				`OFS_MODE: next_s.mode = WDATA;
				`OFS_IO_CTRL: next_s.io = WDATA[2:0];
				`OFS_PRESCALER: begin
					next_s.prescaler = WDATA;
					if (!s.mode[`BIT_RELOAD_ONLY] && s.phase != PH_IDLE) begin
						next_s.pre_cnt = WDATA;
					end
				end
				`OFS_WAIT_LEN: begin
					next_s.wait_len = WDATA;
					if (!s.mode[`BIT_RELOAD_ONLY] && s.phase == PH_WAIT) begin
						next_s.main_cnt = WDATA;
					end
				end
				`OFS_PULSE_LEN: begin
					next_s.pulse_len = WDATA;
					if (!s.mode[`BIT_RELOAD_ONLY] && s.phase == PH_PULSE) begin
						next_s.main_cnt = WDATA;
					end
				end
				default: ;
			endcase
		end

		if (RD) begin
			next_s.rdata = read_reg(ADDR, s);
		end

		if (launch) begin
			next_s.phase = PH_WAIT;
			next_s.pre_cnt = s.prescaler;
			next_s.main_cnt = s.wait_len;
		end

		// Same borrow chain serves both widths; only the low-byte reload differs
		if (tick) begin
			if (s.pre_cnt != 8'h00) begin
				next_s.pre_cnt = s.pre_cnt - 8'h01;
			end else if (s.main_cnt != 8'h00) begin
				next_s.main_cnt = s.main_cnt - 8'h01;
				next_s.pre_cnt = s.mode[`BIT_WIDE] ? `WRAP_LOW : s.prescaler;
			end else begin
				next_s.pre_cnt = s.prescaler;
				case (s.phase)
					PH_WAIT: begin
						next_s.phase = PH_PULSE;
						next_s.main_cnt = s.pulse_len;
					end
					PH_PULSE: begin
						next_s.phase = PH_IDLE;
						next_s.irq_flag = 1'b1;
					end
					default: next_s.phase = PH_IDLE;
				endcase
			end
		end

		// Irq flag deliberately kept: a completion in this cycle is not lost
		if (halt) begin
			next_s.run = 1'b0;
			next_s.active = 1'b0;
			next_s.phase = PH_IDLE;
			next_s.pre_cnt = `RST_COUNT;
			next_s.main_cnt = `RST_COUNT;
			next_s.prescaler = `RST_COUNT;
			next_s.wait_len = `RST_COUNT;
			next_s.pulse_len = `RST_COUNT;
		end

		next_s.pin = pin_level(next_s.phase, next_s.io);
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			s <= '{run: 1'b0, active: 1'b0, phase: PH_IDLE, irq_en: 1'b0, irq_flag: 1'b0,
				mode: `RST_MODE, io: `RST_IO, prescaler: `RST_COUNT, wait_len: `RST_COUNT,
				pulse_len: `RST_COUNT, pre_cnt: `RST_COUNT, main_cnt: `RST_COUNT, div: 4'h0,
				sync: 2'h0, trig_prev: 1'b0, pin: 1'b0, rdata: 8'h00};
		end else begin
			s <= next_s;
		end
	end

	assign RDATA = s.rdata;
	assign PULSE_OUT = s.pin;
	assign IRQ = s.irq_flag & s.irq_en;

	a_run_write: assert property (@(posedge CLOCK) disable iff (RST)
		WR && ADDR == `OFS_CONTROL && !WDATA[`BIT_HALT] |=> s.run == $past(WDATA[`BIT_RUN]))
		else $error("run bit did not follow write");

	a_active_lag: assert property (@(posedge CLOCK) disable iff (RST)
		s.run && !halt |=> s.active ##0 ($past(s.run, 1) == 1'b1))
		else $error("count active flag not set after run");

	a_halt_reinit: assert property (@(posedge CLOCK) disable iff (RST)
		halt |=> !s.run && !s.active && s.phase == PH_IDLE && s.pre_cnt == `RST_COUNT
			&& s.wait_len == `RST_COUNT && PULSE_OUT == pin_level(PH_IDLE, s.io))
		else $error("forced halt left state behind");

	a_halt_read_zero: assert property (@(posedge CLOCK) disable iff (RST)
		RD && ADDR == `OFS_CONTROL |=> !RDATA[`BIT_HALT])
		else $error("halt bit read as one");

	a_irq_gate: assert property (@(posedge CLOCK) disable iff (RST)
		!s.irq_en |-> !IRQ)
		else $error("interrupt not blocked by enable");

	a_irq_clear: assert property (@(posedge CLOCK) disable iff (RST)
		WR && ADDR == `OFS_IRQ_CTRL && !WDATA[`BIT_IRQ_FLAG] && !(tick && s.phase == PH_PULSE)
		|=> !s.irq_flag)
		else $error("request flag not cleared");

	a_mode_gate: assert property (@(posedge CLOCK) disable iff (RST)
		s.phase == PH_IDLE && s.mode[1:0] != `MODE_ONESHOT |=> s.phase == PH_IDLE)
		else $error("one-shot started in wrong mode");

	a_launch_read: assert property (@(posedge CLOCK) disable iff (RST)
		RD && ADDR == `OFS_ONESHOT |=> !RDATA[`BIT_LAUNCH]
			&& RDATA[`BIT_OS_ACTIVE] == ($past(s.phase) != PH_IDLE))
		else $error("one-shot control read wrong");

	a_wait_to_pulse: assert property (@(posedge CLOCK) disable iff (RST)
		tick && !halt && s.phase == PH_WAIT && s.pre_cnt == 8'h00 && s.main_cnt == 8'h00
		|=> s.phase == PH_PULSE && s.main_cnt == $past(s.pulse_len))
		else $error("wait did not hand over to pulse");

	a_done_irq: assert property (@(posedge CLOCK) disable iff (RST)
		tick && s.phase == PH_PULSE && s.pre_cnt == 8'h00 && s.main_cnt == 8'h00
		|=> s.irq_flag && s.phase == PH_IDLE)
		else $error("completion did not raise request");

	a_pin_level: assert property (@(posedge CLOCK) disable iff (RST)
		!s.io[`BIT_POLARITY] && !s.io[`BIT_SWITCH] |-> PULSE_OUT == (s.phase == PH_PULSE))
		else $error("pin level does not match phase");

	a_cutoff_hold: assert property (@(posedge CLOCK) disable iff (RST)
		s.mode[`BIT_CUTOFF] && !WR && !launch |=> $stable(s.pre_cnt) && $stable(s.main_cnt))
		else $error("counter moved with source cut off");

	a_src_half: assert property (@(posedge CLOCK) disable iff (RST)
		tick && s.mode[6:4] == `SRC_DIV2 && !WR |=> !tick)
		else $error("half-rate source ticked twice in a row");

	a_reload_only: assert property (@(posedge CLOCK) disable iff (RST)
		WR && s.mode[`BIT_RELOAD_ONLY] && ADDR == `OFS_WAIT_LEN && !tick && !launch
		|=> $stable(s.main_cnt))
		else $error("reload-only write touched running counter");

	a_wide_wrap: assert property (@(posedge CLOCK) disable iff (RST)
		tick && s.mode[`BIT_WIDE] && s.pre_cnt == 8'h00 && s.main_cnt != 8'h00 && !WR
		|=> s.pre_cnt == `WRAP_LOW)
		else $error("low byte did not wrap in 16-bit mode");

	a_prescale_step: assert property (@(posedge CLOCK) disable iff (RST)
		tick && s.pre_cnt != 8'h00 && !WR |=> s.pre_cnt == $past(s.pre_cnt) - 8'h01)
		else $error("prescaler did not step down");

	a_stop_hold: assert property (@(posedge CLOCK) disable iff (RST)
		!s.run && !WR |=> $stable(s.pre_cnt) && $stable(s.main_cnt))
		else $error("counter moved while stopped");

	a_trig_ignored: assert property (@(posedge CLOCK) disable iff (RST)
		!s.io[`BIT_PIN_TRIG] && !WR && s.phase == PH_IDLE |=> s.phase == PH_IDLE)
		else $error("pin started one-shot while disabled");

	c_launch: cover property (@(posedge CLOCK) disable iff (RST) launch);
	c_pulse: cover property (@(posedge CLOCK) disable iff (RST)
		s.phase == PH_WAIT ##1 s.phase == PH_PULSE);
	c_done: cover property (@(posedge CLOCK) disable iff (RST) $rose(IRQ));
	c_wide_done: cover property (@(posedge CLOCK) disable iff (RST)
		s.mode[`BIT_WIDE] && s.phase == PH_PULSE ##1 s.phase == PH_IDLE);
endmodule
